// *** hw/fbs_regs.svh ***
// Register offsets, field positions, reset values and instruction codes
`ifndef FBS_REGS_SVH
`define FBS_REGS_SVH
`define FBS_OFS_CTRL 12'h000
`define FBS_OFS_STATUS 12'h004
`define FBS_CTRL_MACRO_BIT 0
`define FBS_CTRL_DONE_BIT 1
`define FBS_CTRL_RESET 2'h0
`define FBS_ST_IR_LSB 4
`define FBS_ST_ACTIVE_BIT 8
`define FBS_IR_W 3
`define FBS_IR_EXTEST 3'h0
`define FBS_IR_SAMPLE 3'h1
`define FBS_IR_USER_A 3'h2
`define FBS_IR_USER_B 3'h3
`define FBS_IR_READBACK 3'h4
`define FBS_IR_CONFIG 3'h5
`define FBS_IR_BYPASS 3'h7
`define FBS_IR_CAPTURE 3'h1
`define FBS_AXI_OKAY 2'h0
`define FBS_AXI_SLVERR 2'h2
`endif

// *** hw/fbs_pkg.sv ***
// Types shared by the boundary-scan logic
package fbs_pkg;
	typedef enum logic [3:0] {
		FBS_TLR = 4'h0,
		FBS_RTI = 4'h1,
		FBS_SEL_DR = 4'h3,
		FBS_CAP_DR = 4'h2,
		FBS_SHIFT_DR = 4'h6,
		FBS_EXIT1_DR = 4'h7,
		FBS_PAUSE_DR = 4'h5,
		FBS_EXIT2_DR = 4'h4,
		FBS_UPD_DR = 4'hc,
		FBS_SEL_IR = 4'hd,
		FBS_CAP_IR = 4'hf,
		FBS_SHIFT_IR = 4'he,
		FBS_EXIT1_IR = 4'ha,
		FBS_PAUSE_IR = 4'hb,
		FBS_EXIT2_IR = 4'h9,
		FBS_UPD_IR = 4'h8
	} fbs_tap_e;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} fbs_jtag_s;
endpackage

// *** hw/fbs_scan_top.sv ***
// Boundary-scan test logic: TAP controller, instruction decode, data registers
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "fbs_regs.svh"
module fbs_scan_top
	import fbs_pkg::*;
#(
	parameter int N_IOB = 8
)(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Scan port pins
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	output logic o_tdo,
	output logic o_tdo_oe,
	// Pads and core side of the pad cells
	input wire logic [N_IOB-1:0] i_pad_in,
	input wire logic [N_IOB-1:0] i_core_out,
	input wire logic [N_IOB-1:0] i_core_oe,
	output logic [N_IOB-1:0] o_pad_out,
	output logic [N_IOB-1:0] o_pad_oe,
	output logic [N_IOB-1:0] o_core_in,
	// Mode pins
	input wire logic i_mode_select_low_pin,
	input wire logic i_mode_select_high_pin,
	input wire logic i_mode_select_mid_pin_in,
	input wire logic i_mode_mid_core_out,
	output logic o_mode_select_mid_pin,
	output logic o_mode_select_mid_oe,
	// Internal test taps
	input wire logic i_tdo_t_probe,
	input wire logic i_tdo_o_probe,
	output logic o_internal_update_drive_cell,
	// User scan macro interface
	output logic o_user_instr_a_select,
	output logic o_user_instr_b_select,
	input wire logic i_user_reg_a_return_data,
	input wire logic i_user_reg_b_return_data,
	output logic o_user_shift_clock,
	output logic o_idle_strobe,
	// Scan pins seen by fabric
	output logic o_fab_tck,
	output logic o_fab_tms,
	output logic o_fab_tdi,
	output logic o_scan_pins_user,
	// Configuration through the scan port
	output logic o_cfg_select,
	output logic o_cfg_bit,
	output logic o_cfg_bit_valid,
	output logic o_readback_select,
	input wire logic i_readback_bit,
	// AXI4-Lite slave
	input wire logic [11:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [11:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	// Cell map; configuration start, clock and done pins get no cells
	localparam int IOB0 = 2; // After the two capture cells
	localparam int M_LOW = IOB0 + 3 * N_IOB; // Input cell only
	localparam int M_HIGH = M_LOW + 1; // Input cell only
	localparam int M_MID = M_LOW + 2; // Full three-cell set
	localparam int L = M_MID + 4; // Update cell last

	logic rst_m, rst_n;
	fbs_jtag_s jt_m, jt_s, jt_d;
	logic [N_IOB-1:0] pad_m, pad_s;
	logic [2:0] mpin_m, mpin_s;
	logic tck_rise, tck_fall;
	fbs_tap_e state, next_state;
	logic [`FBS_IR_W-1:0] ir, ir_sr;
	logic [L-1:0] bsr, upd;
	logic bypass_ff, user_a_ff, user_b_ff, rb_ff;
	logic macro_present, config_done, scan_active;
	logic aw_held, w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic extest, sample, sel_a, sel_b, sel_cfg, sel_rb, dr_path_tdo;

	// Reset release through two flops
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_m <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_m <= 1'b1;
			rst_n <= rst_m;
		end
	end

	// Pin synchronisers; the second stage feeds logic, plus a third stage for TCK
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			jt_m <= '0;
			jt_s <= '0;
			jt_d <= '0;
			pad_m <= '0;
			pad_s <= '0;
			mpin_m <= '0;
			mpin_s <= '0;
		end
		else
		begin
			jt_m <= '{tck: i_tck, tms: i_tms, tdi: i_tdi};
			jt_s <= jt_m;
			jt_d <= jt_s;
			pad_m <= i_pad_in;
			pad_s <= pad_m;
			mpin_m <= {i_mode_select_mid_pin_in, i_mode_select_high_pin, i_mode_select_low_pin};
			mpin_s <= mpin_m;
		end
	end

	// TCK edges found on the reference clock; TCK must stay well below 20 MHz
	assign tck_rise = jt_s.tck & ~jt_d.tck;
	assign tck_fall = ~jt_s.tck & jt_d.tck;
	assign scan_active = ~config_done | macro_present;

	// Instruction decode; unknown codes fall back to bypass
	assign extest = (ir == `FBS_IR_EXTEST);
	assign sample = (ir == `FBS_IR_SAMPLE);
	assign sel_a = (ir == `FBS_IR_USER_A);
	assign sel_b = (ir == `FBS_IR_USER_B);
	assign sel_cfg = (ir == `FBS_IR_CONFIG);
	assign sel_rb = (ir == `FBS_IR_READBACK);

	// TAP next state on TMS
	always_comb
	begin
		next_state = state;
		case (state)
			FBS_TLR: next_state = jt_s.tms ? FBS_TLR : FBS_RTI;
			FBS_RTI: next_state = jt_s.tms ? FBS_SEL_DR : FBS_RTI;
			FBS_SEL_DR: next_state = jt_s.tms ? FBS_SEL_IR : FBS_CAP_DR;
			FBS_CAP_DR: next_state = jt_s.tms ? FBS_EXIT1_DR : FBS_SHIFT_DR;
			FBS_SHIFT_DR: next_state = jt_s.tms ? FBS_EXIT1_DR : FBS_SHIFT_DR;
			FBS_EXIT1_DR: next_state = jt_s.tms ? FBS_UPD_DR : FBS_PAUSE_DR;
			FBS_PAUSE_DR: next_state = jt_s.tms ? FBS_EXIT2_DR : FBS_PAUSE_DR;
			FBS_EXIT2_DR: next_state = jt_s.tms ? FBS_UPD_DR : FBS_SHIFT_DR;
			FBS_UPD_DR: next_state = jt_s.tms ? FBS_SEL_DR : FBS_RTI;
			FBS_SEL_IR: next_state = jt_s.tms ? FBS_TLR : FBS_CAP_IR;
			FBS_CAP_IR: next_state = jt_s.tms ? FBS_EXIT1_IR : FBS_SHIFT_IR;
			FBS_SHIFT_IR: next_state = jt_s.tms ? FBS_EXIT1_IR : FBS_SHIFT_IR;
			FBS_EXIT1_IR: next_state = jt_s.tms ? FBS_UPD_IR : FBS_PAUSE_IR;
			FBS_PAUSE_IR: next_state = jt_s.tms ? FBS_EXIT2_IR : FBS_PAUSE_IR;
			FBS_EXIT2_IR: next_state = jt_s.tms ? FBS_UPD_IR : FBS_SHIFT_IR;
			FBS_UPD_IR: next_state = jt_s.tms ? FBS_SEL_DR : FBS_RTI;
			default: next_state = FBS_TLR;
		endcase
	end

	// TAP state on TCK rise; held in reset when scan is released to user I/O
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= FBS_TLR;
		else if (!scan_active)
			state <= FBS_TLR;
		else if (tck_rise)
			state <= next_state;
	end

	// Instruction shift on rise, update on fall in Update-IR
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ir_sr <= `FBS_IR_BYPASS;
			ir <= `FBS_IR_BYPASS;
		end
		else if (state == FBS_TLR)
		begin
			ir_sr <= `FBS_IR_BYPASS;
			ir <= `FBS_IR_BYPASS;
		end
		else
		begin
			if (tck_rise && state == FBS_CAP_IR)
				ir_sr <= `FBS_IR_CAPTURE;
			else if (tck_rise && state == FBS_SHIFT_IR)
				ir_sr <= {jt_s.tdi, ir_sr[`FBS_IR_W-1:1]};
			if (tck_fall && state == FBS_UPD_IR)
				ir <= ir_sr;
		end
	end

	// Boundary register; pad k cells are input, output, enable
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			bsr <= '0;
		else if (tck_rise && state == FBS_CAP_DR && (extest || sample))
		begin
			bsr[0] <= i_tdo_t_probe;
			bsr[1] <= i_tdo_o_probe;
			for (int k = 0; k < N_IOB; k++)
			begin
				bsr[IOB0 + 3 * k] <= pad_s[k];
				bsr[IOB0 + 3 * k + 1] <= extest ? upd[IOB0 + 3 * k + 1] : i_core_out[k];
				bsr[IOB0 + 3 * k + 2] <= extest ? upd[IOB0 + 3 * k + 2] : i_core_oe[k];
			end
			bsr[M_LOW] <= mpin_s[0];
			bsr[M_HIGH] <= mpin_s[1];
			bsr[M_MID] <= mpin_s[2];
			bsr[M_MID + 1] <= extest ? upd[M_MID + 1] : i_mode_mid_core_out;
			bsr[M_MID + 2] <= extest ? upd[M_MID + 2] : 1'b1;
			bsr[L-1] <= upd[L-1];
		end
		else if (tck_rise && state == FBS_SHIFT_DR && (extest || sample))
			bsr <= {jt_s.tdi, bsr[L-1:1]};
	end

	// Update latches load on the fall in Update-DR
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			upd <= '0;
		else if (tck_fall && state == FBS_UPD_DR && (extest || sample))
			upd <= bsr;
	end

	// Single-stage bypass and readback capture
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bypass_ff <= 1'b0;
			rb_ff <= 1'b0;
		end
		else if (tck_rise)
		begin
			if (state == FBS_CAP_DR)
				bypass_ff <= 1'b0;
			else if (state == FBS_SHIFT_DR)
				bypass_ff <= jt_s.tdi;
			if (state == FBS_CAP_DR || state == FBS_SHIFT_DR)
				rb_ff <= i_readback_bit;
		end
	end

	// User return data sampled on the rise so fabric sees a TCK-like timing
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			user_a_ff <= 1'b0;
			user_b_ff <= 1'b0;
		end
		else if (tck_rise)
		begin
			user_a_ff <= i_user_reg_a_return_data;
			user_b_ff <= i_user_reg_b_return_data;
		end
	end

	// Data register chosen for TDO
	always_comb
	begin
		if (sel_a)
			dr_path_tdo = user_a_ff;
		else if (sel_b)
			dr_path_tdo = user_b_ff;
		else if (sel_rb)
			dr_path_tdo = rb_ff;
		else if (extest || sample)
			dr_path_tdo = bsr[0];
		else
			dr_path_tdo = bypass_ff;
	end

	// TDO and its enable change on TCK fall, driven only in shift states
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_tdo <= 1'b0;
			o_tdo_oe <= 1'b0;
		end
		else if (tck_fall)
		begin
			o_tdo <= (state == FBS_SHIFT_IR) ? ir_sr[0] : dr_path_tdo;
			o_tdo_oe <= (state == FBS_SHIFT_IR) || (state == FBS_SHIFT_DR);
		end
	end

	// Pad drive: update cells in external test, core otherwise
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_pad_out <= '0;
			o_pad_oe <= '0;
			o_core_in <= '0;
			o_mode_select_mid_pin <= 1'b0;
			o_mode_select_mid_oe <= 1'b0;
			o_internal_update_drive_cell <= 1'b0;
		end
		else
		begin
			for (int k = 0; k < N_IOB; k++)
			begin
				o_pad_out[k] <= extest ? upd[IOB0 + 3 * k + 1] : i_core_out[k];
				o_pad_oe[k] <= extest ? upd[IOB0 + 3 * k + 2] : i_core_oe[k];
			end
			o_core_in <= pad_s;
			o_mode_select_mid_pin <= extest ? upd[M_MID + 1] : i_mode_mid_core_out;
			o_mode_select_mid_oe <= extest ? upd[M_MID + 2] : 1'b1;
			o_internal_update_drive_cell <= upd[L-1];
		end
	end

	// Fabric strobes and scan pin pass-through
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_user_instr_a_select <= 1'b0;
			o_user_instr_b_select <= 1'b0;
			o_user_shift_clock <= 1'b0;
			o_idle_strobe <= 1'b1;
			o_fab_tck <= 1'b0;
			o_fab_tms <= 1'b0;
			o_fab_tdi <= 1'b0;
			o_scan_pins_user <= 1'b0;
			o_cfg_select <= 1'b0;
			o_readback_select <= 1'b0;
		end
		else
		begin
			o_user_instr_a_select <= sel_a;
			o_user_instr_b_select <= sel_b;
			// Delayed TCK copy lines up with the new TAP state, so no one-cycle slivers
			o_user_shift_clock <= jt_d.tck & (sel_a | sel_b)
				& (state == FBS_CAP_DR || state == FBS_SHIFT_DR);
			o_idle_strobe <= ~(jt_d.tck & (state == FBS_RTI));
			o_fab_tck <= jt_s.tck;
			o_fab_tms <= jt_s.tms;
			o_fab_tdi <= jt_s.tdi;
			o_scan_pins_user <= ~scan_active;
			o_cfg_select <= sel_cfg;
			o_readback_select <= sel_rb;
		end
	end

	// Configuration bits shifted in under the configure instruction
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_cfg_bit <= 1'b0;
			o_cfg_bit_valid <= 1'b0;
		end
		else
		begin
			o_cfg_bit_valid <= tck_rise && sel_cfg && state == FBS_SHIFT_DR;
			if (tck_rise && sel_cfg && state == FBS_SHIFT_DR)
				o_cfg_bit <= jt_s.tdi;
		end
	end

	// AXI write: address and data taken in either order, then response
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			o_bvalid <= 1'b0;
			o_bresp <= `FBS_AXI_OKAY;
			{config_done, macro_present} <= `FBS_CTRL_RESET;
		end
		else
		begin
			if (i_awvalid && o_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
			end
			if (i_wvalid && o_wready)
			begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			if (aw_held && w_held && !o_bvalid)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				o_bvalid <= 1'b1;
				if (aw_addr[11:2] == 10'(`FBS_OFS_CTRL >> 2))
				begin
					o_bresp <= `FBS_AXI_OKAY;
					if (w_strb[0])
					begin
						macro_present <= w_data[`FBS_CTRL_MACRO_BIT];
						config_done <= w_data[`FBS_CTRL_DONE_BIT];
					end
				end
				else if (aw_addr[11:2] == 10'(`FBS_OFS_STATUS >> 2))
					o_bresp <= `FBS_AXI_OKAY;
				else
					o_bresp <= `FBS_AXI_SLVERR;
			end
			else if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
		end
	end

	// Ready outputs registered; each side blocks until its word is used
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
		end
		else
		begin
			o_awready <= !aw_held && !(i_awvalid && o_awready) && !o_bvalid;
			o_wready <= !w_held && !(i_wvalid && o_wready) && !o_bvalid;
		end
	end

	// AXI read: status shows TAP state, instruction and scan activity
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= `FBS_AXI_OKAY;
		end
		else
		begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (i_arvalid && o_arready)
			begin
				o_rvalid <= 1'b1;
				o_rresp <= `FBS_AXI_OKAY;
				o_rdata <= '0;
				if (i_araddr[11:2] == 10'(`FBS_OFS_CTRL >> 2))
				begin
					o_rdata[`FBS_CTRL_MACRO_BIT] <= macro_present;
					o_rdata[`FBS_CTRL_DONE_BIT] <= config_done;
				end
				else if (i_araddr[11:2] == 10'(`FBS_OFS_STATUS >> 2))
				begin
					o_rdata[3:0] <= state;
					o_rdata[`FBS_ST_IR_LSB +: `FBS_IR_W] <= ir;
					o_rdata[`FBS_ST_ACTIVE_BIT] <= scan_active;
				end
				else
					o_rresp <= `FBS_AXI_SLVERR;
			end
			else if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
		end
	end
endmodule

// *** sim/fbs_scan_checker.sv ***
// Concurrent checks on the boundary-scan block ports
`timescale 1ns/1ps
module fbs_scan_checker
	import fbs_pkg::*;
#(
	parameter int N_IOB = 8
)(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Scan pins
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic o_tdo,
	input wire logic o_tdo_oe,
	// Fabric side
	input wire logic o_idle_strobe,
	input wire logic o_fab_tck,
	input wire logic o_fab_tms,
	input wire logic o_user_instr_a_select,
	input wire logic o_user_instr_b_select,
	input wire logic o_user_shift_clock,
	input wire logic o_cfg_select,
	input wire logic o_readback_select,
	input wire logic o_cfg_bit_valid,
	input wire logic o_scan_pins_user,
	// Read channel
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata,
	input wire logic i_rready
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Long enough for the sync chain and output register to settle
	sequence tck_low_run;
		!i_tck [*6];
	endsequence
	sequence tms_steady;
		$stable(i_tms) [*8];
	endsequence
	sequence ar_take;
		i_arvalid && o_arready;
	endsequence
	chk_idle_high: assert property (tck_low_run |-> o_idle_strobe)
		else $error("idle strobe low while TCK low");
	chk_fab_tms: assert property (tms_steady |-> o_fab_tms == i_tms)
		else $error("fabric TMS copy differs from pin");
	chk_fab_tck: assert property ($stable(i_tck) [*6] |-> o_fab_tck == i_tck)
		else $error("fabric TCK copy differs from pin");
	chk_instr_onehot: assert property ($onehot0({o_user_instr_a_select,
		o_user_instr_b_select, o_cfg_select, o_readback_select}))
		else $error("more than one instruction select high");
	// TDO moves only in the low half of TCK, never near its rise
	chk_tdo_fall: assert property ($changed(o_tdo) || $changed(o_tdo_oe) |-> !$past(i_tck, 2))
		else $error("TDO changed outside the TCK low phase");
	chk_user_clk: assert property (o_user_shift_clock |->
		o_user_instr_a_select || o_user_instr_b_select)
		else $error("user shift clock without user instruction");
	chk_cfg_pulse: assert property (o_cfg_bit_valid |-> o_cfg_select ##1 !o_cfg_bit_valid)
		else $error("configuration bit strobe malformed");
	chk_pins_free: assert property (o_scan_pins_user |->
		!o_tdo_oe && !o_user_shift_clock)
		else $error("scan logic active with pins handed to user");
	chk_read_lat: assert property (ar_take |=> o_rvalid)
		else $error("read answer late");
	chk_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read answer dropped before taken");
endmodule

bind fbs_scan_top fbs_scan_checker #(.N_IOB(N_IOB)) chk_u (.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n), .i_tck(i_tck), .i_tms(i_tms), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
	.o_idle_strobe(o_idle_strobe), .o_fab_tck(o_fab_tck), .o_fab_tms(o_fab_tms),
	.o_user_instr_a_select(o_user_instr_a_select), .o_user_instr_b_select(o_user_instr_b_select),
	.o_user_shift_clock(o_user_shift_clock), .o_cfg_select(o_cfg_select),
	.o_readback_select(o_readback_select), .o_cfg_bit_valid(o_cfg_bit_valid),
	.o_scan_pins_user(o_scan_pins_user), .i_arvalid(i_arvalid), .o_arready(o_arready),
	.o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_rready(i_rready));

// *** sim/fbs_tester.sv ***
// Scan tester model driving the test access port pins
`timescale 1ns/1ps
module fbs_tester (
	// Reference clock
	input wire logic i_ref_clk,
	// Scan pins
	input wire logic i_tdo,
	input wire logic i_tdo_oe,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi
);
	// TCK stands low and TMS high between frames
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// One 200 ns TCK period; an undriven TDO reads as unknown
	task automatic cyc(input logic tms, input logic tdi, output logic tdo);
		repeat (2) @(posedge i_ref_clk);
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (3) @(posedge i_ref_clk);
		tdo = i_tdo_oe ? i_tdo : 1'bx;
		o_tck <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		o_tck <= 1'b0;
	endtask
	// Five ones reach reset from any state, then park in idle
	task automatic reset_tap();
		logic b;
		repeat (5) cyc(1'b1, 1'b0, b);
		cyc(1'b0, 1'b1, b);
	endtask
	// Instruction or data scan from idle back to idle, LSB first
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic b;
		dout = '0;
		cyc(1'b1, 1'b1, b);
		if (ir)
			cyc(1'b1, 1'b0, b);
		cyc(1'b0, 1'b1, b);
		cyc(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++)
		begin
			cyc(i == n - 1, din[i], b);
			dout[i] = b;
		end
		cyc(1'b1, ~din[n-1], b);
		cyc(1'b0, din[n-1], b);
		@(posedge i_ref_clk);
		o_tms <= 1'b1;
	endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the boundary-scan block
`timescale 1ns/1ps
`include "fbs_regs.svh"
module tb;
	localparam int N = 4;
	localparam int L = 3 * N + 8;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe, m_lo, m_hi, m_mid, m_core, mid_o, mid_oe, p_t, p_o, upd;
	logic sel_a, sel_b, ret_a, ret_b, ushift, idle, f_tck, f_tms, f_tdi, pins_user;
	logic cfg_sel, cfg_bit, cfg_v, rb_sel, rb_bit;
	logic [N-1:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] cfg_sh = 8'h0;
	int cfg_n = 0;
	int error_cnt = 0;
	int comparisons = 0;
	int idle_n = 0;
	int ush_n = 0;
	logic idle_q = 1'b1;
	logic ush_q = 1'b0;

	// 40 MHz reference clock
	always #12.5 i_ref_clk = ~i_ref_clk;

	fbs_scan_top #(.N_IOB(N)) dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tck(tck),
		.i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pad_in(pad_in),
		.i_core_out(core_out), .i_core_oe(core_oe), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
		.o_core_in(core_in), .i_mode_select_low_pin(m_lo), .i_mode_select_high_pin(m_hi),
		.i_mode_select_mid_pin_in(m_mid), .i_mode_mid_core_out(m_core),
		.o_mode_select_mid_pin(mid_o), .o_mode_select_mid_oe(mid_oe), .i_tdo_t_probe(p_t),
		.i_tdo_o_probe(p_o), .o_internal_update_drive_cell(upd), .o_user_instr_a_select(sel_a),
		.o_user_instr_b_select(sel_b), .i_user_reg_a_return_data(ret_a),
		.i_user_reg_b_return_data(ret_b), .o_user_shift_clock(ushift), .o_idle_strobe(idle),
		.o_fab_tck(f_tck), .o_fab_tms(f_tms), .o_fab_tdi(f_tdi), .o_scan_pins_user(pins_user),
		.o_cfg_select(cfg_sel), .o_cfg_bit(cfg_bit), .o_cfg_bit_valid(cfg_v),
		.o_readback_select(rb_sel), .i_readback_bit(rb_bit), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

	fbs_tester tst_u (.i_ref_clk(i_ref_clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck),
		.o_tms(tms), .o_tdi(tdi));

	// Gather configuration bits as the block hands them on
	always @(posedge i_ref_clk)
		if (cfg_v === 1'b1)
		begin
			cfg_sh <= {cfg_bit, cfg_sh[7:1]};
			cfg_n <= cfg_n + 1;
		end

	// Count idle strobe falls and user clock rises for pulse checks
	always @(posedge i_ref_clk)
	begin
		idle_q <= idle;
		ush_q <= ushift;
		if (idle_q === 1'b1 && idle === 1'b0)
			idle_n <= idle_n + 1;
		if (ush_q === 1'b0 && ushift === 1'b1)
			ush_n <= ush_n + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Write with address and data offered together
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge i_ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge i_ref_clk);
			if (awvalid && awready === 1'b1)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge i_ref_clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	// Read; rready raised late so the answer must stand
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge i_ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge i_ref_clk); while (rvalid !== 1'b1);
		rready <= 1'b1;
		@(posedge i_ref_clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Load an instruction; the capture pattern comes back first
	task automatic load_ir(input logic [2:0] code);
		logic [31:0] q;
		tst_u.scan(1'b1, 3, {29'h0, code}, q);
		chk(q, 32'h1);
	endtask

	// Expected boundary register contents, update cell left as zero
	function automatic logic [31:0] br(input logic [N-1:0] o, input logic [N-1:0] e,
		input logic mo, input logic me);
		logic [31:0] v;
		v = '0;
		v[0] = p_t;
		v[1] = p_o;
		for (int k = 0; k < N; k++)
			v[4+3*k -: 3] = {e[k], o[k], pad_in[k]};
		v[3*N+6 -: 5] = {me, mo, m_mid, m_hi, m_lo};
		return v;
	endfunction

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd(`FBS_OFS_CTRL, d, r);
		chk(d, 32'h0);
		rd(`FBS_OFS_STATUS, d, r);
		chk(d, 32'h170);
		rd(12'h008, d, r);
		chk({d[29:0], r}, {30'h0, `FBS_AXI_SLVERR});
		wr(12'h010, 32'h3, r);
		chk(32'(r), 32'(`FBS_AXI_SLVERR));
	endtask

	task automatic t_bypass();
		logic [31:0] q;
		load_ir(`FBS_IR_BYPASS);
		tst_u.scan(1'b0, 8, 32'h96, q);
		chk(q, 32'h2c);
		chk(32'(f_tdi), 32'h1);
	endtask

	// Sample, then external test on what sample left in the update latches
	task automatic t_boundary();
		logic [31:0] q, pat;
		logic [N-1:0] eo, ee;
		pat = 32'ha5c3b;
		@(posedge i_ref_clk);
		{pad_in, core_out, core_oe} <= 12'h536;
		{m_lo, m_hi, m_mid, m_core, p_t, p_o} <= 6'h2a;
		load_ir(`FBS_IR_SAMPLE);
		tst_u.scan(1'b0, L, pat, q);
		chk(q & 32'h7ffff, br(core_out, core_oe, m_core, 1'b1));
		for (int k = 0; k < N; k++)
			{ee[k], eo[k]} = pat[4+3*k -: 2];
		load_ir(`FBS_IR_EXTEST);
		chk({pad_out, pad_oe}, {eo, ee});
		chk({mid_o, mid_oe, upd}, {pat[3*N+5], pat[3*N+6], pat[L-1]});
		tst_u.scan(1'b0, L + 4, 32'h600009, q);
		chk(q & 32'h7ffff, br(eo, ee, pat[3*N+5], pat[3*N+6]));
		chk(32'(q[23:20]), 32'h9);
		chk({pad_out, pad_oe, mid_o, mid_oe, upd}, 11'h006);
		load_ir(`FBS_IR_BYPASS);
		chk({pad_out, pad_oe, core_in, mid_oe}, {core_out, core_oe, pad_in, 1'b1});
	endtask

	task automatic t_user();
		logic [31:0] q, d;
		logic [1:0] r;
		logic b;
		int n0;
		@(posedge i_ref_clk);
		ret_a <= 1'b1;
		ret_b <= 1'b0;
		n0 = ush_n;
		load_ir(`FBS_IR_USER_A);
		chk(32'({sel_a, sel_b}), 32'h2);
		rd(`FBS_OFS_STATUS, d, r);
		chk(d, 32'h121);
		tst_u.scan(1'b0, 8, 32'h0, q);
		chk(q & 32'hfe, 32'hfe);
		chk(ush_n - n0, 9);
		repeat (4) @(posedge i_ref_clk);
		n0 = idle_n;
		repeat (3) tst_u.cyc(1'b0, 1'b0, b);
		repeat (4) @(posedge i_ref_clk);
		chk(idle_n - n0, 3);
		load_ir(`FBS_IR_USER_B);
		chk(32'({sel_a, sel_b}), 32'h1);
		tst_u.scan(1'b0, 8, 32'hff, q);
		chk(q & 32'hfe, 32'h0);
	endtask

	task automatic t_cfg();
		logic [31:0] q;
		int n0;
		@(posedge i_ref_clk);
		rb_bit <= 1'b1;
		load_ir(`FBS_IR_CONFIG);
		chk(32'({cfg_sel, rb_sel}), 32'h2);
		n0 = cfg_n;
		tst_u.scan(1'b0, 8, 32'hb4, q);
		chk({24'(cfg_n - n0), cfg_sh}, 32'h8b4);
		load_ir(`FBS_IR_READBACK);
		chk(32'({cfg_sel, rb_sel}), 32'h1);
		tst_u.scan(1'b0, 8, 32'h0, q);
		chk(q & 32'hfe, 32'hfe);
	endtask

	// Done without the macro frees the pins; the macro brings scan back
	task automatic t_pins();
		logic [31:0] q, d;
		logic [1:0] r;
		wr(`FBS_OFS_CTRL, 32'h2, r);
		rd(`FBS_OFS_STATUS, d, r);
		chk({d[30:0] & 31'h10f, pins_user}, 32'h1);
		tst_u.scan(1'b1, 3, 32'h1, q);
		chk(q, {29'h0, 3'hx});
		wr(`FBS_OFS_CTRL, 32'h3, r);
		rd(`FBS_OFS_CTRL, d, r);
		chk({d[30:0], pins_user}, {31'h3, 1'b0});
		tst_u.reset_tap();
		load_ir(`FBS_IR_BYPASS);
	endtask

	initial
	begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		{pad_in, core_out, core_oe, m_lo, m_hi, m_mid, m_core, p_t, p_o} = '0;
		{ret_a, ret_b, rb_bit} = 3'h0;
		repeat (20) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		t_regs();
		tst_u.reset_tap();
		t_bypass();
		t_boundary();
		t_user();
		t_cfg();
		t_pins();
		end_of_test();
	end

	// Watchdog on the whole run
	initial
	begin
		repeat (40000) @(posedge i_ref_clk);
		error_cnt++;
		end_of_test();
	end
endmodule
